//--- hw/flc_bus_cycle.sv
/*
  One asynchronous flash bus cycle (single write or single read) with
  chip select, strobes and the data bus enable driven from flip-flops.
  Assumes the caller waits for done before starting the next cycle.
*/
`timescale 1ns/1ps
module flc_bus_cycle
  import flc_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // Request and answer
  input  wire logic                start,
  input  wire logic                is_write,
  input  wire logic [FLASH_AW-1:0] addr,
  input  wire logic [FLASH_DW-1:0] wdata,
  output logic                     done,
  output logic      [FLASH_DW-1:0] rdata,
  // Flash pins
  output logic      [FLASH_AW-1:0] flash_addr,
  input  wire logic [FLASH_DW-1:0] flash_dq_i,
  output logic      [FLASH_DW-1:0] flash_dq_o,
  output logic                     flash_dq_oe,
  output logic                     chip_select_0_n,
  output logic                     flash_oe_n,
  output logic                     flash_we_n
);
  import flc_pkg::*;

  typedef enum logic [2:0] {
    BC_IDLE   = 3'b000,
    BC_SETUP  = 3'b001,
    BC_STROBE = 3'b010,
    BC_HOLD   = 3'b011,
    BC_GAP    = 3'b100
  } flc_bc_state_t;

  flc_bc_state_t       state_q, state_d;
  logic [7:0]          cnt_q, cnt_d;
  logic                wr_q, wr_d;
  logic [FLASH_AW-1:0] addr_q, addr_d;
  logic [FLASH_DW-1:0] wdata_q, wdata_d;
  logic [FLASH_DW-1:0] rdata_q, rdata_d;
  logic                ce_n_q, ce_n_d;
  logic                oe_n_q, oe_n_d;
  logic                we_n_q, we_n_d;
  logic                dq_oe_q, dq_oe_d;
  logic                done_q, done_d;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    wr_d    = wr_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d  = 1'b0;
    case (state_q)
      BC_IDLE: begin
        if (start) begin
          wr_d    = is_write;
          addr_d  = addr;
          wdata_d = wdata;
          state_d = BC_SETUP;
        end
      end
      BC_SETUP: begin
        cnt_d   = wr_q ? WE_LOW_CYC : RD_CYC;
        state_d = BC_STROBE;
      end
      BC_STROBE: begin
        if (cnt_q <= CNT_ONE) begin
          if (!wr_q) begin
            rdata_d = flash_dq_i;
          end
          state_d = BC_HOLD;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      BC_HOLD: begin
        // Deselect after every access, so no read is ever a page hit
        cnt_d   = wr_q ? W12_CYC : OE_HIGH_CYC;  // [RQ6] [RQ4] [RQ2]
        state_d = BC_GAP;
      end
      BC_GAP: begin
        if (cnt_q <= CNT_ONE) begin
          done_d  = 1'b1;
          state_d = BC_IDLE;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default: state_d = BC_IDLE;
    endcase
    // Pins follow the next state so they toggle on clean register edges
    ce_n_d  = !(state_d == BC_SETUP || state_d == BC_STROBE || state_d == BC_HOLD);
    oe_n_d  = !(state_d == BC_STROBE && !wr_d);
    we_n_d  = !(state_d == BC_STROBE && wr_d);
    dq_oe_d = wr_d && !ce_n_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= BC_IDLE;
      cnt_q   <= '0;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      dq_oe_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      ce_n_q  <= ce_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      dq_oe_q <= dq_oe_d;
      done_q  <= done_d;
    end
  end

  assign done            = done_q;
  assign rdata           = rdata_q;
  assign flash_addr      = addr_q;
  assign flash_dq_o      = wdata_q;
  assign flash_dq_oe     = dq_oe_q;
  assign chip_select_0_n = ce_n_q;
  assign flash_oe_n      = oe_n_q;
  assign flash_we_n      = we_n_q;

endmodule

//--- hw/flc_pkg.sv
/*
  Constants shared by the flash status controller: register map, field
  positions, operation codes, pin widths and bus-cycle timing.
  Assumes a 100 MHz pclk and an asynchronous parallel flash on the pins.
*/
// Notes on behaviour
// [RQ1] Status command makes later reads return status
// [RQ2] Status reads are single accesses, no paging
// [RQ3] Flash latches status on OE or CE edge
// [RQ4] Raise OE or deselect between status reads
// [RQ5] Status command works at any supply level
// [RQ6] Wait write-to-read interval before reading status
// [RQ7] Busy: only ready bit driven, rest floating
// [RQ8] Ready or suspended: whole status byte valid
// [RQ9] Ready on bit 7 and pin; poll it
// [RQ10] Bits 6..0 undriven while ready bit zero
// [RQ11] Status bits 6..1 carry six event flags
// [RQ12] Both error bits set: bad command sequence
// [RQ13] Locked-block bit only reflects checked operations
// [RQ14] Lock bits sampled only after command sequences
// [RQ15] Read lock state through identifier mode instead
// [RQ16] Status bit 0 reserved; mask when polling
// [RQ17] Buffer status bit 7 shows buffer available
// [RQ18] Buffer status bits 6..0 reserved; mask them
// [RQ19] Buffer setup with block address loads status
// [RQ20] Error bits set: buffer writes refused
// [RQ21] Clear status after a program error
package flc_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int FLASH_AW = 24;
  localparam int FLASH_DW = 16;
  localparam int APB_AW   = 12;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [APB_AW-1:0] REG_CTRL   = 12'h000;
  localparam logic [APB_AW-1:0] REG_ADDR   = 12'h004;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h008;

  // CTRL fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_OP_MSB = 2;

  // STATUS fields; bits 7..0 hold the masked operation status
  localparam int ST_BUF_AVAIL = 8;
  localparam int ST_BUSY      = 9;
  localparam int ST_READY_PIN = 10;
  localparam int ST_REFUSED   = 11;
  localparam int ST_SEQ_ERR   = 12;
  localparam int ST_NEED_CLR  = 13;

  // Operation status bit positions
  localparam int SB_READY      = 7;
  localparam int SB_ERASE_SUSP = 6;
  localparam int SB_ERASE_ERR  = 5;
  localparam int SB_PROG_ERR   = 4;
  localparam int SB_LOW_VPP    = 3;
  localparam int SB_PROG_SUSP  = 2;
  localparam int SB_LOCK_ABORT = 1;
  localparam int SB_RESERVED   = 0;

  // Valid bits: bit 0 reserved, and only bit 7 of buffer status
  localparam logic [7:0] STATUS_MASK = 8'hfe;
  localparam logic [7:0] BUSY_MASK   = 8'h80;
  localparam logic [7:0] BUFST_MASK  = 8'h80;

  // ************************************************************
  // Operations requested through CTRL
  // ************************************************************
  typedef enum logic [1:0] {
    FLC_OP_POLL  = 2'b00,
    FLC_OP_READ  = 2'b01,
    FLC_OP_CLEAR = 2'b10,
    FLC_OP_BUFQ  = 2'b11
  } flc_op_t;

  // Command bytes (fixed package localparams; the top has no parameters to override them)
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_BUFFER_SETUP = 8'he8;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_NS       = 10;
  localparam int WE_LOW_NS    = 70;
  localparam int RD_ACCESS_NS = 150;
  localparam int W12_NS       = 210;
  localparam int OE_HIGH_NS   = 30;

  localparam int WE_LOW_CYC_I  = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC_I      = (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int W12_CYC_I     = (W12_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_HIGH_CYC_I = (OE_HIGH_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] WE_LOW_CYC  = 8'(WE_LOW_CYC_I);
  localparam logic [7:0] RD_CYC      = 8'(RD_CYC_I);
  localparam logic [7:0] W12_CYC     = 8'(W12_CYC_I);
  localparam logic [7:0] OE_HIGH_CYC = 8'(OE_HIGH_CYC_I);
  localparam logic [7:0] CNT_ONE     = 8'h01;

endpackage

//--- hw/flc_status_ctrl.sv
/*
  Host-side status controller for a parallel NOR flash. Software sets an
  address and starts an operation over APB; the controller issues the
  flash commands, polls the status byte and reports the masked result.
  Assumes chip select 0 selects the flash and the other selects are tied
  active outside, and that the flash pins are synchronous to pclk.
*/
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module flc_status_ctrl
  import flc_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [APB_AW-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Flash pins
  output logic      [FLASH_AW-1:0] flash_addr,
  input  wire logic [FLASH_DW-1:0] flash_dq_i,
  output logic      [FLASH_DW-1:0] flash_dq_o,
  output logic                     flash_dq_oe,
  output logic                     chip_select_0_n,
  output logic                     flash_oe_n,
  output logic                     flash_we_n,
  input  wire logic                ready_pin
);
  import flc_pkg::*;

  typedef enum logic [2:0] {
    OP_IDLE   = 3'b000,
    OP_CMD    = 3'b001,
    OP_CMD_W  = 3'b010,
    OP_READ   = 3'b011,
    OP_READ_W = 3'b100
  } flc_op_state_t;

  // Status byte with reserved bits removed
  function automatic logic [7:0] flc_mask(input logic [7:0] raw, input logic [7:0] mask);
    flc_mask = raw & mask;
  endfunction

  flc_op_state_t       state_q, state_d;
  flc_op_t             op_q, op_d;
  logic [FLASH_AW-1:0] addr_reg_q, addr_reg_d;
  logic [7:0]          status_q, status_d;
  logic                buf_avail_q, buf_avail_d;
  logic                refused_q, refused_d;
  logic                bc_start;
  logic                bc_write;
  logic [FLASH_DW-1:0] bc_wdata;
  logic                bc_done;
  logic [FLASH_DW-1:0] bc_rdata;
  logic [7:0]          rd_byte;
  logic                apb_wr;
  logic                start_req;
  logic                mapped;
  logic [7:0]          cmd_byte;

  assign apb_wr    = psel && penable && pwrite;
  assign start_req = apb_wr && (paddr == REG_CTRL) && pwdata[CTRL_START];
  assign rd_byte   = bc_rdata[7:0];

  // ************************************************************
  // Command selection
  // ************************************************************
  always_comb begin
    case (op_q)
      FLC_OP_CLEAR: cmd_byte = CMD_CLEAR_STATUS;  // [RQ21]
      FLC_OP_BUFQ:  cmd_byte = CMD_BUFFER_SETUP;  // [RQ19]
      default:      cmd_byte = CMD_READ_STATUS;   // [RQ1] [RQ5]
    endcase
  end

  // ************************************************************
  // Operation sequencer
  // ************************************************************
  always_comb begin
    state_d     = state_q;
    op_d        = op_q;
    addr_reg_d  = addr_reg_q;
    status_d    = status_q;
    buf_avail_d = buf_avail_q;
    refused_d   = refused_q;
    bc_start    = 1'b0;
    bc_write    = 1'b0;
    bc_wdata    = {8'h00, cmd_byte};
    if (apb_wr && paddr == REG_ADDR) begin
      addr_reg_d = pwdata[FLASH_AW-1:0];
    end
    case (state_q)
      OP_IDLE: begin
        if (start_req) begin
          op_d      = flc_op_t'(pwdata[CTRL_OP_MSB:CTRL_OP_LSB]);
          refused_d = 1'b0;
          // A latched error blocks buffer setup until cleared
          if (op_d == FLC_OP_BUFQ && (status_q[SB_ERASE_ERR] || status_q[SB_PROG_ERR])) begin
            refused_d = 1'b1;  // [RQ20] [RQ21]
          end else begin
            state_d = OP_CMD;
          end
        end
      end
      OP_CMD: begin
        bc_start = 1'b1;
        bc_write = 1'b1;
        state_d  = OP_CMD_W;
      end
      OP_CMD_W: begin
        if (bc_done) begin
          if (op_q == FLC_OP_CLEAR) begin
            status_d = '0;
            state_d  = OP_IDLE;
          end else begin
            // Status is only taken after a command sequence was written
            state_d = OP_READ;  // [RQ6] [RQ14]
          end
        end
      end
      OP_READ: begin
        bc_start = 1'b1;
        state_d  = OP_READ_W;
      end
      OP_READ_W: begin
        if (bc_done) begin
          if (op_q == FLC_OP_BUFQ) begin
            buf_avail_d = flc_mask(rd_byte, BUFST_MASK) != 8'h00;  // [RQ17] [RQ18]
            state_d     = OP_IDLE;
          end else if (!rd_byte[SB_READY]) begin
            // Only the ready bit is driven while busy; floating bits dropped
            status_d = flc_mask(rd_byte, BUSY_MASK);  // [RQ7] [RQ10]
            state_d  = (op_q == FLC_OP_POLL) ? OP_READ : OP_IDLE;  // [RQ9]
          end else begin
            status_d = flc_mask(rd_byte, STATUS_MASK);  // [RQ8] [RQ11] [RQ16]
            state_d  = OP_IDLE;
          end
        end
      end
      default: state_d = OP_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= OP_IDLE;
      op_q        <= FLC_OP_POLL;
      addr_reg_q  <= '0;
      status_q    <= '0;
      buf_avail_q <= 1'b0;
      refused_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      op_q        <= op_d;
      addr_reg_q  <= addr_reg_d;
      status_q    <= status_d;
      buf_avail_q <= buf_avail_d;
      refused_q   <= refused_d;
    end
  end

  // ************************************************************
  // Flash bus cycles
  // ************************************************************
  // Each read is a fresh select with OE falling, so the flash relatches
  flc_bus_cycle u_cycle (  // [RQ3] [RQ4]
    .pclk            (pclk),
    .presetn         (presetn),
    .start           (bc_start),
    .is_write        (bc_write),
    .addr            (addr_reg_q),
    .wdata           (bc_wdata),
    .done            (bc_done),
    .rdata           (bc_rdata),
    .flash_addr      (flash_addr),
    .flash_dq_i      (flash_dq_i),
    .flash_dq_o      (flash_dq_o),
    .flash_dq_oe     (flash_dq_oe),
    .chip_select_0_n (chip_select_0_n),
    .flash_oe_n      (flash_oe_n),
    .flash_we_n      (flash_we_n)
  );

  // ************************************************************
  // APB read side
  // ************************************************************
  // Zero wait states; unmapped addresses read zero and flag an error
  always_comb begin
    prdata = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == REG_CTRL) begin
      prdata[CTRL_OP_MSB:CTRL_OP_LSB] = op_q;
      prdata[CTRL_START]              = (state_q != OP_IDLE);
    end else if (paddr == REG_ADDR) begin
      prdata[FLASH_AW-1:0] = addr_reg_q;
    end else if (paddr == REG_STATUS) begin
      prdata[7:0]          = status_q;
      prdata[ST_BUF_AVAIL] = buf_avail_q;
      prdata[ST_BUSY]      = (state_q != OP_IDLE);
      prdata[ST_READY_PIN] = ready_pin;  // [RQ9]
      prdata[ST_REFUSED]   = refused_q;
      // Lock abort is only a per-operation result, not a lock indicator
      prdata[ST_SEQ_ERR]   = status_q[SB_ERASE_ERR] && status_q[SB_PROG_ERR];  // [RQ12] [RQ13]
      prdata[ST_NEED_CLR]  = status_q[SB_ERASE_ERR] || status_q[SB_PROG_ERR];  // [RQ21]
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

endmodule

//--- verification/flc_checker.sv
/*
  Port checker for the flash status controller.
  Assumes a bind from the bench and a single pclk domain.
*/
`timescale 1ns/1ps
module flc_checker (
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // APB
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [flc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0]               prdata,
  // Flash pins
  input wire logic                      flash_dq_oe,
  input wire logic                      chip_select_0_n,
  input wire logic                      flash_oe_n,
  input wire logic                      flash_we_n,
  input wire logic                      ready_pin
);
  import flc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****
  // Helpers
  // ****
  logic [7:0] gap_q, gap_d;
  logic       rp1_q, rp1_d, rp2_q, rp2_d;
  logic       st_rd;
  assign st_rd = psel && penable && !pwrite && paddr == REG_STATUS;
  always_comb begin
    gap_d = gap_q;
    rp1_d = ready_pin;
    rp2_d = rp1_q;
    if (!flash_we_n) gap_d = 8'h00;
    else if (gap_q != 8'hff) gap_d = gap_q + 8'h01;
  end
  // Saturated gap at reset: no write has happened yet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'hff;
      rp1_q <= 1'b0;
      rp2_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      rp1_q <= rp1_d;
      rp2_q <= rp2_d;
    end
  end

  // ****
  // Assertions
  // ****
  // Compared without an increment: the saturated gap must not wrap to zero
  chk_w12_gap: assert property ($fell(flash_oe_n) |-> gap_q >= W12_CYC)
    else $error("read strobe too soon after a write");
  chk_oe_release: assert property ($rose(flash_oe_n) |=> chip_select_0_n)
    else $error("select held past a read");
  chk_fresh_select: assert property ($fell(flash_oe_n) |-> !$past(chip_select_0_n) && $past(chip_select_0_n, 2))
    else $error("read without a fresh select edge");
  chk_we_width: assert property ($fell(flash_we_n) |-> !flash_we_n [*7] ##1 flash_we_n)
    else $error("write strobe width wrong");
  chk_no_clash: assert property (flash_dq_oe |-> flash_oe_n && !chip_select_0_n)
    else $error("data bus driven during a read");
  chk_bit0_masked: assert property (st_rd |-> !prdata[SB_RESERVED])
    else $error("reserved status bit not masked");
  chk_busy_masked: assert property (st_rd && !prdata[SB_READY] |-> prdata[6:0] == 7'h00)
    else $error("floating status bits reported while busy");
  chk_ready_pin: assert property (st_rd && rp1_q == ready_pin && rp2_q == ready_pin |-> prdata[ST_READY_PIN] == ready_pin)
    else $error("ready pin not reflected");
endmodule

//--- verification/flc_flash_model.sv
/*
  Behavioural flash device: status and buffer status reads, clear.
  Assumes pins change just after pclk edges; bench sets busy and flags.
*/
`timescale 1ns/1ps
module flc_flash_model (
  // Clock
  input  wire logic        pclk,
  // Flash pins
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [15:0] dq,
  output logic      [15:0] dq_drv,
  output logic             ready_pin,
  // Bench controls
  input  wire logic        busy,
  input  wire logic        buf_ok,
  input  wire logic [5:0]  set_flags,
  output logic      [7:0]  last_cmd
);
  import flc_pkg::*;
  logic [15:0] lat_q, pat_q;
  logic [5:0]  sr_q;
  logic        cs_q, oe_q, we_q, xsr_q;
  initial begin
    {lat_q, pat_q, sr_q, xsr_q, last_cmd} = '0;
    {cs_q, oe_q, we_q} = 3'b111;
  end
  assign ready_pin = !busy;
  // No pull-ups: released lines show a changing pattern
  assign dq_drv = (!cs_n && !oe_n) ? lat_q : ~pat_q;
  always @(posedge pclk) begin
    pat_q <= pat_q + 16'h3a5b;
    cs_q <= cs_n;
    oe_q <= oe_n;
    we_q <= we_n;
    sr_q <= sr_q | set_flags;
    if (!we_q && we_n && !cs_n) begin
      last_cmd <= dq[7:0];
      xsr_q <= 1'b0;
      if (dq[7:0] == CMD_CLEAR_STATUS) sr_q <= 6'h00;
      if (dq[7:0] == CMD_BUFFER_SETUP && !sr_q[4] && !sr_q[3]) xsr_q <= 1'b1;
    end
    if (!cs_n && !oe_n && (oe_q || cs_q)) begin
      if (xsr_q) lat_q <= {~pat_q[15:8], buf_ok, 7'h7f};
      else if (busy) lat_q <= {~pat_q[15:8], 1'b0, ~pat_q[6:0]};
      else lat_q <= {8'h00, 1'b1, sr_q, 1'b1};
    end
  end
endmodule

//--- verification/flc_status_ctrl_test.sv
/*
  Self-checking bench for the flash status controller over APB.
  Assumes the flash model answers on the pins and the checker is bound.
*/
`timescale 1ns/1ps
module flc_status_ctrl_test;
  import flc_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0]   paddr;
  logic [31:0]         pwdata, prdata, st;
  logic                dq_oe, cs_n, oe_n, we_n, rdy, busy, buf_ok;
  logic [FLASH_AW-1:0] faddr;
  logic [15:0]         dq_o, dev_dq, dq;
  logic [5:0]          set_flags;
  logic [7:0]          last_cmd;
  int                  miscompares, cmp_count, cyc;
  assign dq = dq_oe ? dq_o : dev_dq;

  flc_status_ctrl i_flc_status_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(faddr), .flash_dq_i(dq), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .chip_select_0_n(cs_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .ready_pin(rdy));
  flc_flash_model i_flc_flash_model (.pclk(pclk), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .dq(dq),
    .dq_drv(dev_dq), .ready_pin(rdy), .busy(busy), .buf_ok(buf_ok), .set_flags(set_flags),
    .last_cmd(last_cmd));

  // ****
  // Bus and compare tasks
  // ****
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [APB_AW-1:0] a, logic [31:0] d, output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic op(flc_op_t o);
    logic [31:0] q;
    logic        e;
    apb(1'b1, REG_CTRL, {29'h0, o, 1'b1}, q, e);
  endtask
  task automatic wait_idle();
    logic e;
    int   n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, st, e);
      n++;
    end while (st[ST_BUSY] !== 1'b0 && n < 500);
    cmp("op finished", 32'h0, {31'h0, st[ST_BUSY]});
  endtask
  task automatic results();
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    apb(1'b0, REG_CTRL, 32'h0, q, e);
    cmp("ctrl reset", 32'h0, q);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    cmp("status reset", 32'h0, q & 32'hfffffbff);
    apb(1'b1, REG_ADDR, 32'hffffffff, q, e);
    apb(1'b0, REG_ADDR, 32'h0, q, e);
    cmp("addr", 32'h00ffffff, q);
    cmp("mapped", 32'h0, {31'h0, e});
    apb(1'b1, REG_STATUS, 32'h3fff, q, e);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    cmp("status ro", 32'h0, q & 32'hfffffbff);
    apb(1'b0, 12'h0fc, 32'h0, q, e);
    cmp("unmapped", 32'h1, {31'h0, e});
  endtask
  task automatic t_poll();
    logic [31:0] q;
    logic        e;
    busy <= 1'b1;
    set_flags <= 6'h15;
    @(posedge pclk);
    set_flags <= 6'h00;
    op(FLC_OP_POLL);
    repeat (300) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, q, e);
    cmp("busy while polling", 32'h1, {31'h0, q[ST_BUSY]});
    busy <= 1'b0;
    wait_idle();
    cmp("polled status", 32'haa, {24'h0, st[7:0]});
    cmp("ready pin", 32'h1, {31'h0, st[ST_READY_PIN]});
    cmp("error summary", 32'h2, {30'h0, st[ST_NEED_CLR], st[ST_SEQ_ERR]});
    cmp("status command", {24'h0, CMD_READ_STATUS}, {24'h0, last_cmd});
    op(FLC_OP_BUFQ);
    wait_idle();
    cmp("buffer refused", 32'h1, {31'h0, st[ST_REFUSED]});
    cmp("no buffer setup", {24'h0, CMD_READ_STATUS}, {24'h0, last_cmd});
    op(FLC_OP_CLEAR);
    wait_idle();
    cmp("cleared", 32'h0, {24'h0, st[7:0]});
    op(FLC_OP_READ);
    wait_idle();
    cmp("after clear", 32'h80, {24'h0, st[7:0]});
  endtask
  task automatic t_busy_read();
    busy <= 1'b1;
    op(FLC_OP_READ);
    wait_idle();
    cmp("busy status", 32'h0, {24'h0, st[7:0]});
    cmp("busy pin", 32'h0, {31'h0, st[ST_READY_PIN]});
    busy <= 1'b0;
  endtask
  task automatic t_bufq();
    logic [31:0] q;
    logic        e;
    apb(1'b1, REG_ADDR, 32'h0002_0000, q, e);
    for (int i = 0; i < 2; i++) begin
      buf_ok <= i[0];
      op(FLC_OP_BUFQ);
      wait_idle();
      cmp("buffer flag", i, {31'h0, st[ST_BUF_AVAIL]});
      cmp("setup command", {24'h0, CMD_BUFFER_SETUP}, {24'h0, last_cmd});
      cmp("block address", 32'h0002_0000, {8'h00, faddr});
    end
    set_flags <= 6'h18;
    @(posedge pclk);
    set_flags <= 6'h00;
    op(FLC_OP_READ);
    wait_idle();
    cmp("sequence error", 32'hb0, {24'h0, st[7:0]});
    cmp("both errors", 32'h1, {31'h0, st[ST_SEQ_ERR]});
    op(FLC_OP_CLEAR);
    wait_idle();
  endtask

  // ****
  // Clock, reset, sequence, timeout
  // ****
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {busy, buf_ok, set_flags, miscompares, cmp_count, cyc} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_poll();
    t_busy_read();
    t_bufq();
    results();
  end
endmodule

bind flc_status_ctrl flc_checker i_flc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .flash_dq_oe(flash_dq_oe),
  .chip_select_0_n(chip_select_0_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .ready_pin(ready_pin));
